// >>> inc/dmas_map.vh
// Constants of the dual multiply add/sub slice: offsets, fields, codes
`ifndef DMAS_MAP_VH
`define DMAS_MAP_VH

// ----------------------------------------------------------------------
// Datapath widths
// ----------------------------------------------------------------------
`define DMAS_OPND_W        18
`define DMAS_HALF_W        9
`define DMAS_ACC_W         52
`define DMAS_RES_W         72
`define DMAS_RPOS_W        6

// ----------------------------------------------------------------------
// Register port
// ----------------------------------------------------------------------
`define DMAS_ADDR_W        8
`define DMAS_OFS_CFG       8'h00
`define DMAS_OFS_STATUS    8'h04
`define DMAS_OFS_MASK      8'h08
`define DMAS_OFS_ACC_LO    8'h0c
`define DMAS_OFS_ACC_HI    8'h10

// ----------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------
`define DMAS_CFG_W         15
`define DMAS_CFG_IN_REG    0
`define DMAS_CFG_PIPE_REG  1
`define DMAS_CFG_OUT_REG   2
`define DMAS_CFG_ASYNC     3
`define DMAS_CFG_DYNAMIC   4
`define DMAS_CFG_SUB       5
`define DMAS_CFG_SHIFT     6
`define DMAS_CFG_CASC      7
`define DMAS_CFG_RND_EN    8
`define DMAS_CFG_RPOS_LSB  9
`define DMAS_CFG_RPOS_MSB  14
`define DMAS_CFG_RESET     15'h0007

// ----------------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------------
`define DMAS_ST_W          2
`define DMAS_ST_OVF        0
`define DMAS_ST_UNF        1
`define DMAS_ST_RESET      2'h0

// ----------------------------------------------------------------------
// Function select codes
// ----------------------------------------------------------------------
`define DMAS_OP_SINGLE     2'h0
`define DMAS_OP_DUAL       2'h1
`define DMAS_OP_MAC        2'h2
`define DMAS_OP_IDLE       2'h3

`endif

// >>> design/dmas_oprnd_reg.v
// Operand register with parallel or shift load and optional bypass
`timescale 1ns/100ps
`include "dmas_map.vh"

module dmas_oprnd_reg (
   // Clock and resets
   input  wire                     clock_i,
   input  wire                     arst_n_i,
   input  wire                     srst_i,
   // Control
   input  wire                     reg_en_i,
   input  wire                     shift_i,
   // Data
   input  wire [`DMAS_OPND_W-1:0]  par_i,
   input  wire [`DMAS_OPND_W-1:0]  chain_i,
   output wire [`DMAS_OPND_W-1:0]  q_o,
   output wire [`DMAS_OPND_W-1:0]  hold_o
);

   reg  [`DMAS_OPND_W-1:0] q_reg;
   wire [`DMAS_OPND_W-1:0] q_next;

   // ---------------------------------------------------------------
   // Load source
   // ---------------------------------------------------------------
   assign q_next = shift_i ? chain_i : par_i;

   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q_reg <= {`DMAS_OPND_W{1'b0}};
      end else if (srst_i) begin
         q_reg <= {`DMAS_OPND_W{1'b0}};
      end else begin
         q_reg <= q_next;
      end
   end

   // Bypassed stage adds no latency
   assign q_o    = reg_en_i ? q_reg : par_i;
   assign hold_o = q_reg;

endmodule

// >>> design/dmas_conv_round.v
// Convergent (round half to even) rounding of a signed result
`timescale 1ns/100ps
`include "dmas_map.vh"

module dmas_conv_round (
   // Control
   input  wire                     en_i,
   input  wire [`DMAS_RPOS_W-1:0]  pos_i,
   // Data
   input  wire [`DMAS_ACC_W-1:0]   val_i,
   output reg  [`DMAS_ACC_W-1:0]   val_o,
   output reg                      ovf_o
);

   reg [`DMAS_ACC_W-1:0] one;
   reg [`DMAS_ACC_W-1:0] low_mask;
   reg [`DMAS_ACC_W-1:0] half;
   reg [`DMAS_ACC_W-1:0] low;
   reg [`DMAS_ACC_W-1:0] base;
   reg [`DMAS_ACC_W:0]   up;
   reg                   rnd_up;

   // ---------------------------------------------------------------
   // Round at bit position, ties go to even
   // ---------------------------------------------------------------
   always @* begin
      one      = {{(`DMAS_ACC_W-1){1'b0}}, 1'b1} << pos_i;
      low_mask = one - {{(`DMAS_ACC_W-1){1'b0}}, 1'b1};
      half     = one >> 1;
      low      = val_i & low_mask;
      base     = val_i & ~low_mask;
      rnd_up   = (low > half) || ((low == half) && ((val_i & one) != 0));
      up       = {base[`DMAS_ACC_W-1], base};
      val_o    = val_i;
      ovf_o    = 1'b0;
      if (en_i && (pos_i != 6'h00) && (pos_i < 6'h34)) begin
         if (rnd_up) begin
            up = {base[`DMAS_ACC_W-1], base} + {1'b0, one};
         end
         if (up[`DMAS_ACC_W] != up[`DMAS_ACC_W-1]) begin
            ovf_o = 1'b1;
            val_o = {1'b0, {(`DMAS_ACC_W-1){1'b1}}};
         end else begin
            val_o = up[`DMAS_ACC_W-1:0];
         end
      end
   end

endmodule

// >>> design/dmas_slice.v
// Dual multiply add/sub slice: operands, products, sum, accumulator
`timescale 1ns/100ps
`include "dmas_map.vh"

// Contract
// - Dual mode: two products, then add/subtract them
// - Input, pipeline, output stages each bypassable
// - Operand registers load parallel or by shifting
// - Dynamic mode: add/subtract chosen every cycle
// - Dynamic mode: parallel or shift load per cycle
// - Synchronous reset, optionally asynchronous instead
// - Function selects may change every cycle
// - Four x9, two x18 products, one MAC
// - Detect overflow/underflow; convergent rounding
// - Cascade paths to neighbouring slices
module dmas_slice (
   // Clock and reset
   input  wire                     clock_i,
   input  wire                     reset_n_i,
   // Register port
   input  wire [`DMAS_ADDR_W-1:0]  reg_addr_i,
   input  wire [31:0]              reg_wdata_i,
   input  wire                     reg_wr_i,
   input  wire                     reg_rd_i,
   output wire [31:0]              reg_rdata_o,
   // Operands
   input  wire [`DMAS_OPND_W-1:0]  first_pair_left_operand_i,
   input  wire [`DMAS_OPND_W-1:0]  first_pair_right_operand_i,
   input  wire [`DMAS_OPND_W-1:0]  second_pair_left_operand_i,
   input  wire [`DMAS_OPND_W-1:0]  second_pair_right_operand_i,
   // Per-cycle controls
   input  wire [1:0]               op_sel_i,
   input  wire                     width_x9_i,
   input  wire                     add_sub_i,
   input  wire                     shift_load_i,
   input  wire                     slice_rst_i,
   // Cascade in
   input  wire [`DMAS_OPND_W-1:0]  shift_left_i,
   input  wire [`DMAS_OPND_W-1:0]  shift_right_i,
   input  wire [`DMAS_RES_W-1:0]   cascade_i,
   // Results
   output wire [`DMAS_RES_W-1:0]   result_o,
   output wire                     overflow_o,
   output wire                     underflow_o,
   // Cascade out
   output wire [`DMAS_OPND_W-1:0]  shift_left_o,
   output wire [`DMAS_OPND_W-1:0]  shift_right_o,
   output wire [`DMAS_RES_W-1:0]   cascade_o,
   // Interrupt
   output wire                     irq_o
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function [53:0] sx36;
      input [35:0] p;
      sx36 = {{18{p[35]}}, p};
   endfunction

   function [35:0] ext18;
      input [17:0] q;
      ext18 = {{18{q[17]}}, q};
   endfunction

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   reg rst_meta_reg;
   reg rst_sync_reg;

   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   reg  [`DMAS_CFG_W-1:0]  cfg_reg;
   reg  [`DMAS_ST_W-1:0]   mask_reg;
   reg  [`DMAS_ST_W-1:0]   status_reg;
   reg  [`DMAS_ST_W-1:0]   status_next;
   reg  [31:0]             rdata_reg;
   reg  [31:0]             rdata_next;
   reg  [`DMAS_ACC_W-1:0]  acc_reg;
   wire [`DMAS_ST_W-1:0]   evt;
   wire                    rd_status;

   wire cfg_in    = cfg_reg[`DMAS_CFG_IN_REG];
   wire cfg_pipe  = cfg_reg[`DMAS_CFG_PIPE_REG];
   wire cfg_out   = cfg_reg[`DMAS_CFG_OUT_REG];
   wire cfg_async = cfg_reg[`DMAS_CFG_ASYNC];
   wire cfg_dyn   = cfg_reg[`DMAS_CFG_DYNAMIC];
   wire cfg_casc  = cfg_reg[`DMAS_CFG_CASC];
   wire cfg_rnd   = cfg_reg[`DMAS_CFG_RND_EN];
   wire [`DMAS_RPOS_W-1:0] cfg_rpos =
      cfg_reg[`DMAS_CFG_RPOS_MSB:`DMAS_CFG_RPOS_LSB];

   assign rd_status = reg_rd_i && (reg_addr_i == `DMAS_OFS_STATUS);

   always @* begin
      rdata_next = 32'h00000000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `DMAS_OFS_CFG:    rdata_next = {17'h00000, cfg_reg};
            `DMAS_OFS_STATUS: rdata_next = {30'h00000000, status_reg};
            `DMAS_OFS_MASK:   rdata_next = {30'h00000000, mask_reg};
            `DMAS_OFS_ACC_LO: rdata_next = acc_reg[31:0];
            `DMAS_OFS_ACC_HI: rdata_next = {12'h000, acc_reg[51:32]};
            default:          rdata_next = 32'h00000000;
         endcase
      end
      // Set wins over read clear
      status_next = (rd_status ? `DMAS_ST_RESET : status_reg) | evt;
   end

   always @(posedge clock_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         cfg_reg    <= `DMAS_CFG_RESET;
         mask_reg   <= `DMAS_ST_RESET;
         status_reg <= `DMAS_ST_RESET;
         rdata_reg  <= 32'h00000000;
      end else begin
         status_reg <= status_next;
         rdata_reg  <= rdata_next;
         if (reg_wr_i && (reg_addr_i == `DMAS_OFS_CFG)) begin
            cfg_reg <= reg_wdata_i[`DMAS_CFG_W-1:0];
         end
         if (reg_wr_i && (reg_addr_i == `DMAS_OFS_MASK)) begin
            mask_reg <= reg_wdata_i[`DMAS_ST_W-1:0];
         end
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign irq_o       = |(status_reg & mask_reg);

   // ---------------------------------------------------------------
   // Datapath reset selection
   // ---------------------------------------------------------------
   wire dp_arst_n = rst_sync_reg & ~(cfg_async & slice_rst_i);
   wire dp_srst   = ~cfg_async & slice_rst_i;

   // ---------------------------------------------------------------
   // Input stage
   // ---------------------------------------------------------------
   wire sub_sel   = cfg_dyn ? add_sub_i : cfg_reg[`DMAS_CFG_SUB];
   wire shift_sel = cfg_dyn ? shift_load_i
                            : cfg_reg[`DMAS_CFG_SHIFT];
   wire [3:0] ctl0 = {op_sel_i, width_x9_i, sub_sel};

   wire [`DMAS_OPND_W-1:0] fpl, fpr, spl, spr;
   wire [`DMAS_OPND_W-1:0] fpl_hold, fpr_hold;

   dmas_oprnd_reg u_fpl (.clock_i(clock_i), .arst_n_i(dp_arst_n),
      .srst_i(dp_srst), .reg_en_i(cfg_in), .shift_i(shift_sel),
      .par_i(first_pair_left_operand_i), .chain_i(shift_left_i),
      .q_o(fpl), .hold_o(fpl_hold));

   dmas_oprnd_reg u_fpr (.clock_i(clock_i), .arst_n_i(dp_arst_n),
      .srst_i(dp_srst), .reg_en_i(cfg_in), .shift_i(shift_sel),
      .par_i(first_pair_right_operand_i), .chain_i(shift_right_i),
      .q_o(fpr), .hold_o(fpr_hold));

   dmas_oprnd_reg u_spl (.clock_i(clock_i), .arst_n_i(dp_arst_n),
      .srst_i(dp_srst), .reg_en_i(cfg_in), .shift_i(shift_sel),
      .par_i(second_pair_left_operand_i), .chain_i(fpl_hold),
      .q_o(spl), .hold_o(shift_left_o));

   dmas_oprnd_reg u_spr (.clock_i(clock_i), .arst_n_i(dp_arst_n),
      .srst_i(dp_srst), .reg_en_i(cfg_in), .shift_i(shift_sel),
      .par_i(second_pair_right_operand_i), .chain_i(fpr_hold),
      .q_o(spr), .hold_o(shift_right_o));

   // ---------------------------------------------------------------
   // Multipliers
   // ---------------------------------------------------------------
   wire signed [35:0] pa = $signed(fpl) * $signed(fpr);
   wire signed [35:0] pb = $signed(spl) * $signed(spr);
   wire signed [17:0] q0 = $signed(fpl[8:0]) * $signed(fpr[8:0]);
   wire signed [17:0] q1 = $signed(fpl[17:9]) * $signed(fpr[17:9]);
   wire signed [17:0] q2 = $signed(spl[8:0]) * $signed(spr[8:0]);
   wire signed [17:0] q3 = $signed(spl[17:9]) * $signed(spr[17:9]);

   // ---------------------------------------------------------------
   // Pipeline stage
   // ---------------------------------------------------------------
   reg [3:0]  ctl1_reg, ctl2_reg;
   reg [35:0] pa_reg, pb_reg;
   reg [17:0] q0_reg, q1_reg, q2_reg, q3_reg;

   wire [3:0]  ctl1 = cfg_in ? ctl1_reg : ctl0;
   wire [3:0]  ctl2 = cfg_pipe ? ctl2_reg : ctl1;
   wire [35:0] pa_p = cfg_pipe ? pa_reg : pa;
   wire [35:0] pb_p = cfg_pipe ? pb_reg : pb;
   wire [17:0] q0_p = cfg_pipe ? q0_reg : q0;
   wire [17:0] q1_p = cfg_pipe ? q1_reg : q1;
   wire [17:0] q2_p = cfg_pipe ? q2_reg : q2;
   wire [17:0] q3_p = cfg_pipe ? q3_reg : q3;

   wire [1:0] op  = ctl2[3:2];
   wire       w9  = ctl2[1];
   wire       sub = ctl2[0];

   // ---------------------------------------------------------------
   // Sum and accumulate
   // ---------------------------------------------------------------
   reg  [53:0]             s_base;
   reg  [53:0]             s_term;
   reg  [53:0]             s_sum;
   reg  [53:0]             s_casc;
   reg  [35:0]             lo9;
   reg  [35:0]             hi9;
   reg                     s_ovf;
   reg                     s_unf;
   reg  [`DMAS_ACC_W-1:0]  sat;
   reg  [`DMAS_ACC_W-1:0]  acc_next;
   reg  [`DMAS_RES_W-1:0]  res_next;
   wire [`DMAS_ACC_W-1:0]  rnd;
   wire                    rnd_ovf;
   wire                    scalar;

   assign scalar = (op == `DMAS_OP_MAC) || ((op == `DMAS_OP_DUAL) && !w9);

   always @* begin
      s_casc = cfg_casc ? {{2{cascade_i[51]}}, cascade_i[51:0]}
                        : 54'h00000000000000;
      if (op == `DMAS_OP_MAC) begin
         s_base = {{2{acc_reg[51]}}, acc_reg};
         s_term = w9 ? sx36(ext18(q0_p)) : sx36(pa_p);
      end else begin
         s_base = sx36(pa_p);
         s_term = sx36(pb_p);
      end
      s_sum = (sub ? (s_base - s_term) : (s_base + s_term)) + s_casc;
      s_ovf = ~s_sum[53] & (s_sum[52] | s_sum[51]);
      s_unf = s_sum[53] & ~(s_sum[52] & s_sum[51]);
      if (s_ovf) begin
         sat = {1'b0, {(`DMAS_ACC_W-1){1'b1}}};
      end else if (s_unf) begin
         sat = {1'b1, {(`DMAS_ACC_W-1){1'b0}}};
      end else begin
         sat = s_sum[`DMAS_ACC_W-1:0];
      end
      lo9 = sub ? (ext18(q0_p) - ext18(q2_p))
                : (ext18(q0_p) + ext18(q2_p));
      hi9 = sub ? (ext18(q1_p) - ext18(q3_p))
                : (ext18(q1_p) + ext18(q3_p));
      // Accumulator holds outside its own function
      acc_next = (op == `DMAS_OP_MAC) ? sat : acc_reg;
      case (op)
         `DMAS_OP_SINGLE:
            res_next = w9 ? {q3_p, q2_p, q1_p, q0_p}
                          : {pb_p, pa_p};
         `DMAS_OP_DUAL:
            res_next = w9 ? {hi9, lo9} : {{20{rnd[51]}}, rnd};
         `DMAS_OP_MAC:
            res_next = {{20{rnd[51]}}, rnd};
         default:
            res_next = {`DMAS_RES_W{1'b0}};
      endcase
   end

   dmas_conv_round u_round (
      .en_i    (cfg_rnd),
      .pos_i   (cfg_rpos),
      .val_i   (sat),
      .val_o   (rnd),
      .ovf_o   (rnd_ovf)
   );

   wire ovf_next = scalar & (s_ovf | rnd_ovf);
   wire unf_next = scalar & s_unf;

   assign evt[`DMAS_ST_OVF] = ovf_next;
   assign evt[`DMAS_ST_UNF] = unf_next;

   // ---------------------------------------------------------------
   // Datapath registers
   // ---------------------------------------------------------------
   reg [`DMAS_RES_W-1:0] res_reg;
   reg                   ovf_reg;
   reg                   unf_reg;

   always @(posedge clock_i or negedge dp_arst_n) begin
      if (!dp_arst_n || dp_srst) begin
         ctl1_reg <= 4'h0;
         ctl2_reg <= 4'h0;
         pa_reg   <= 36'h000000000;
         pb_reg   <= 36'h000000000;
         q0_reg   <= 18'h00000;
         q1_reg   <= 18'h00000;
         q2_reg   <= 18'h00000;
         q3_reg   <= 18'h00000;
         acc_reg  <= {`DMAS_ACC_W{1'b0}};
         res_reg  <= {`DMAS_RES_W{1'b0}};
         ovf_reg  <= 1'b0;
         unf_reg  <= 1'b0;
      end else begin
         ctl1_reg <= ctl0;
         ctl2_reg <= ctl1;
         pa_reg   <= pa;
         pb_reg   <= pb;
         q0_reg   <= q0;
         q1_reg   <= q1;
         q2_reg   <= q2;
         q3_reg   <= q3;
         acc_reg  <= acc_next;
         res_reg  <= res_next;
         ovf_reg  <= ovf_next;
         unf_reg  <= unf_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign result_o    = cfg_out ? res_reg : res_next;
   assign overflow_o  = cfg_out ? ovf_reg : ovf_next;
   assign underflow_o = cfg_out ? unf_reg : unf_next;
   assign cascade_o   = result_o;

endmodule

// >>> tb/dmas_slice_props.sv
// Port-level assertions of the dual multiply add/sub slice
`timescale 1ns/100ps
`include "dmas_map.vh"

module dmas_slice_props (
   // Clock and reset
   input wire                    clock_i,
   input wire                    reset_n_i,
   // Observed ports
   input wire                    reg_rd_i,
   input wire                    reg_wr_i,
   input wire [31:0]             reg_rdata_o,
   input wire                    slice_rst_i,
   input wire [`DMAS_RES_W-1:0]  result_o,
   input wire                    overflow_o,
   input wire                    underflow_o,
   input wire [`DMAS_OPND_W-1:0] shift_left_o,
   input wire [`DMAS_OPND_W-1:0] shift_right_o,
   input wire [`DMAS_RES_W-1:0]  cascade_o,
   input wire                    irq_o
);
   sequence s_chain_zero;
      shift_left_o == 0 && shift_right_o == 0;
   endsequence
   sequence s_result_zero;
      result_o == 0 && !overflow_o && !underflow_o;
   endsequence

   a_flags_apart: assert property (
      @(posedge clock_i) disable iff (!reset_n_i)
      !(overflow_o && underflow_o))
      else $error("overflow and underflow both high");
   a_casc_mirror: assert property (
      @(posedge clock_i) disable iff (!reset_n_i) cascade_o == result_o)
      else $error("cascade out differs from result");
   a_reset_chain: assert property (
      @(posedge clock_i) !reset_n_i |=> s_chain_zero)
      else $error("shift chain not cleared by reset");
   a_reset_result: assert property (
      @(posedge clock_i) !reset_n_i |=> s_result_zero)
      else $error("result not cleared by reset");
   a_reset_irq: assert property (
      @(posedge clock_i) !reset_n_i |=> !irq_o)
      else $error("interrupt high during reset");
   a_slice_clear: assert property (
      @(posedge clock_i) disable iff (!reset_n_i)
      slice_rst_i |-> ##1 s_chain_zero)
      else $error("slice reset left operand registers");
   a_irq_fall: assert property (
      @(posedge clock_i) disable iff (!reset_n_i)
      $fell(irq_o) |-> $past(reg_rd_i) || $past(reg_wr_i) ||
         $past(reg_rd_i, 2) || $past(reg_wr_i, 2))
      else $error("interrupt dropped without register access");
   a_rdata_idle: assert property (
      @(posedge clock_i) disable iff (!reset_n_i)
      !$past(reg_rd_i) |-> reg_rdata_o == 0)
      else $error("read data outside read answer cycle");
endmodule

// >>> tb/dmas_fabric_mdl.sv
// Fabric-side model driving operands and per-cycle controls
`timescale 1ns/100ps
`include "dmas_map.vh"

module dmas_fabric_mdl (
   // Clock
   input  wire                    clock_i,
   // Operands and controls to the slice
   output reg  [`DMAS_OPND_W-1:0] fpl_o,
   output reg  [`DMAS_OPND_W-1:0] fpr_o,
   output reg  [`DMAS_OPND_W-1:0] spl_o,
   output reg  [`DMAS_OPND_W-1:0] spr_o,
   output reg  [1:0]              op_o,
   output reg                     x9_o,
   output reg                     sub_o,
   output reg                     shl_o,
   output reg                     srst_o
);
   initial begin
      {fpl_o, fpr_o, spl_o, spr_o} = 72'h0;
      {op_o, x9_o, sub_o, shl_o, srst_o} = {`DMAS_OP_IDLE, 4'h0};
   end
   // New function, operands and load style on any cycle
   task put(input [1:0] op, input x9, input sub, input shl, input srst,
            input [17:0] a, input [17:0] b, input [17:0] c,
            input [17:0] d);
      @(posedge clock_i);
      op_o   <= op;
      sub_o  <= sub;
      shl_o  <= shl;
      x9_o   <= x9;
      srst_o <= srst;
      {fpl_o, fpr_o, spl_o, spr_o} <= {a, b, c, d};
   endtask
endmodule

// >>> tb/dual_multiply_add_sub_slice_tb_top.sv
// Self-checking bench of the dual multiply add/sub slice
`timescale 1ns/100ps
`include "dmas_map.vh"
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin fails++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end

module dual_multiply_add_sub_slice_tb_top;
   localparam longint LIM = (64'sd1 <<< 51) - 1;
   logic        clock_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic [7:0]  reg_addr_i = 8'h0;
   logic [31:0] reg_wdata_i = 32'h0, rv;
   logic [17:0] shift_left_i = 18'h0, shift_right_i = 18'h0, a, b, c, d;
   logic [71:0] cascade_i = 72'h0, e;
   wire  [71:0] result_o, cascade_o;
   wire  [31:0] reg_rdata_o;
   wire  [17:0] fpl, fpr, spl, spr, shift_left_o, shift_right_o;
   wire  [1:0]  op;
   wire         x9, sub, shl, srst, overflow_o, underflow_o, irq_o;
   int          fails = 0, n_compared = 0, i;
   longint      acc = 0;

   always #2 clock_i = ~clock_i;

   dmas_fabric_mdl fab_u (.clock_i(clock_i), .fpl_o(fpl), .fpr_o(fpr),
      .spl_o(spl), .spr_o(spr), .op_o(op), .x9_o(x9), .sub_o(sub),
      .shl_o(shl), .srst_o(srst));
   dmas_slice dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .first_pair_left_operand_i(fpl), .first_pair_right_operand_i(fpr),
      .second_pair_left_operand_i(spl), .second_pair_right_operand_i(spr),
      .op_sel_i(op), .width_x9_i(x9), .add_sub_i(sub), .shift_load_i(shl),
      .slice_rst_i(srst), .shift_left_i(shift_left_i),
      .shift_right_i(shift_right_i), .cascade_i(cascade_i),
      .result_o(result_o), .overflow_o(overflow_o),
      .underflow_o(underflow_o), .shift_left_o(shift_left_o),
      .shift_right_o(shift_right_o), .cascade_o(cascade_o), .irq_o(irq_o));

   // -------------------------------------------------------------------
   // Reference model and bus tasks
   // -------------------------------------------------------------------
   function automatic longint sx(input [17:0] v, input int w);
      return w == 9 ? longint'($signed(v[8:0])) : longint'($signed(v));
   endfunction
   function automatic longint sat(input longint r);
      return r > LIM ? LIM : (r < -LIM - 1 ? -LIM - 1 : r);
   endfunction
   function [71:0] model(input [1:0] o, input x9, input s,
                         input [17:0] a, b, c, d, input longint cs);
      longint pa, pb, q0, q1, q2, q3, r;
      pa = sx(a, 18) * sx(b, 18);
      pb = sx(c, 18) * sx(d, 18);
      q0 = sx(a, 9) * sx(b, 9);
      q1 = sx(a >> 9, 9) * sx(b >> 9, 9);
      q2 = sx(c, 9) * sx(d, 9);
      q3 = sx(c >> 9, 9) * sx(d >> 9, 9);
      case (o)
         `DMAS_OP_SINGLE: model = x9 ? {q3[17:0], q2[17:0], q1[17:0],
            q0[17:0]} : {pb[35:0], pa[35:0]};
         `DMAS_OP_DUAL: begin
            r = x9 ? (s ? q1 - q3 : q1 + q3)
               : sat((s ? pa - pb : pa + pb) + cs);
            pb = s ? q0 - q2 : q0 + q2;
            model = x9 ? {r[35:0], pb[35:0]} : 72'(r);
         end
         `DMAS_OP_MAC: begin
            r = x9 ? q0 : pa;
            acc = sat((s ? acc - r : acc + r) + cs);
            model = 72'(acc);
         end
         default: model = 72'h0;
      endcase
   endfunction
   task wr(input [7:0] ad, input [31:0] dt);
      @(posedge clock_i);
      {reg_addr_i, reg_wdata_i, reg_wr_i} <= {ad, dt, 1'b1};
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   task chk_rd(input string nm, input [7:0] ad, input [31:0] m,
               input [31:0] ex);
      @(posedge clock_i);
      {reg_addr_i, reg_rd_i} <= {ad, 1'b1};
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      @(negedge clock_i);
      rv = reg_rdata_o;
      `CHK(nm, ex, rv & m)
   endtask
   task run(input [1:0] o, input x9, input s, input int lat);
      logic [71:0] m;
      {a, b, c, d} = {$urandom, $urandom, 8'($urandom)};
      m = (o == `DMAS_OP_MAC || (o == `DMAS_OP_DUAL && !x9)) ?
         {20'h0, {52{1'b1}}} : {72{1'b1}};
      fab_u.put(o, x9, s, 1'b0, 1'b0, a, b, c, d);
      e = model(o, x9, s, a, b, c, d, 0);
      repeat (lat) @(posedge clock_i);
      @(negedge clock_i);
      `CHK("result", e & m, result_o & m)
   endtask
   task finish_test;
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   initial begin
      #20000;
      fails++;
      finish_test;
   end
   initial begin
      void'($urandom(32'h8bcd));
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk_rd("cfg", `DMAS_OFS_CFG, 32'h7fff, 32'h7);
      chk_rd("status", `DMAS_OFS_STATUS, 32'h3, 32'h0);
      chk_rd("mask", `DMAS_OFS_MASK, 32'h3, 32'h0);
      chk_rd("unmapped", 8'h20, 32'hffffffff, 32'h0);
      $display("test reset done");
      {a, b, c, d} = {$urandom, $urandom, 8'($urandom)};
      fab_u.put(`DMAS_OP_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0, a, b, c, d);
      e = model(`DMAS_OP_SINGLE, 1'b0, 1'b0, a, b, c, d, 0);
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      `CHK("early", 72'h0, result_o)
      @(negedge clock_i);
      `CHK("latency", e, result_o)
      run(`DMAS_OP_SINGLE, 1'b1, 1'b0, 3);
      $display("test latency done");
      wr(`DMAS_OFS_CFG, 32'h10);
      fab_u.put(`DMAS_OP_IDLE, 1'b0, 1'b0, 1'b0, 1'b1, 0, 0, 0, 0);
      acc = 0;
      for (i = 0; i < 16; i++)
         run(2'(i % 4), i[2], 1'($urandom), 0);
      chk_rd("acc_lo", `DMAS_OFS_ACC_LO, 32'hffffffff, acc[31:0]);
      chk_rd("acc_hi", `DMAS_OFS_ACC_HI, 32'hfffff, 32'(acc[51:32]));
      $display("test dynamic done");
      wr(`DMAS_OFS_CFG, 32'h90);
      wr(`DMAS_OFS_MASK, 32'h3);
      fab_u.put(`DMAS_OP_DUAL, 1'b0, 1'b0, 1'b0, 1'b0, 1, 1, 0, 0);
      cascade_i <= {21'h0, {51{1'b1}}};
      @(negedge clock_i);
      `CHK("sat_hi", 52'h7ffffffffffff, result_o[51:0])
      `CHK("ovf", 1'b1, overflow_o)
      fab_u.put(`DMAS_OP_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, 0, 0, 0, 0);
      @(negedge clock_i);
      `CHK("irq_on", 1'b1, irq_o)
      chk_rd("st_ovf", `DMAS_OFS_STATUS, 32'h3, 32'h1);
      `CHK("irq_off", 1'b0, irq_o)
      wr(`DMAS_OFS_MASK, 32'h1);
      fab_u.put(`DMAS_OP_DUAL, 1'b0, 1'b1, 1'b0, 1'b0, 1, 18'h3ffff, 0, 0);
      cascade_i <= {21'h1fffff, 51'h0};
      @(negedge clock_i);
      `CHK("sat_lo", 52'h8000000000000, result_o[51:0])
      `CHK("unf", 1'b1, underflow_o)
      fab_u.put(`DMAS_OP_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, 0, 0, 0, 0);
      @(negedge clock_i);
      `CHK("irq_mask", 1'b0, irq_o)
      chk_rd("st_unf", `DMAS_OFS_STATUS, 32'h3, 32'h2);
      $display("test saturation done");
      wr(`DMAS_OFS_CFG, 32'h11);
      {a, b, c, d} = {$urandom, $urandom, 8'($urandom)};
      fab_u.put(`DMAS_OP_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, a, b, c, d);
      {shift_left_i, shift_right_i} <= 36'($urandom);
      @(posedge clock_i);
      @(negedge clock_i);
      `CHK("par", {c, d}, {shift_left_o, shift_right_o})
      fab_u.put(`DMAS_OP_IDLE, 1'b0, 1'b0, 1'b1, 1'b0, a, b, c, d);
      @(posedge clock_i);
      @(negedge clock_i);
      `CHK("shift1", {a, b}, {shift_left_o, shift_right_o})
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      `CHK("shift2", {shift_left_i, shift_right_i},
         {shift_left_o, shift_right_o})
      wr(`DMAS_OFS_CFG, 32'h19);
      fab_u.put(`DMAS_OP_IDLE, 1'b0, 1'b0, 1'b1, 1'b1, a, b, c, d);
      #1;
      `CHK("async", 36'h0, {shift_left_o, shift_right_o})
      fab_u.put(`DMAS_OP_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, a, b, c, d);
      $display("test operand load done");
      finish_test;
   end
endmodule

bind dmas_slice dmas_slice_props props_u (.clock_i(clock_i),
   .reset_n_i(reset_n_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
   .reg_rdata_o(reg_rdata_o), .slice_rst_i(slice_rst_i),
   .result_o(result_o), .overflow_o(overflow_o),
   .underflow_o(underflow_o), .shift_left_o(shift_left_o),
   .shift_right_o(shift_right_o), .cascade_o(cascade_o), .irq_o(irq_o));
